// [hw/camera_capture_pkg.sv]
// camera capture control: register map, field layout, codes, timing
// assumes a 200 MHz block clock and an APB slave with 32-bit data
package camera_capture_pkg;

  localparam int ADDR_W = 16;

  // register indices; the byte address is four times the index
  localparam logic [15:0] IDX_CONFIG  = 16'h2010;
  localparam logic [15:0] IDX_FRAME   = 16'h2012;
  localparam logic [15:0] IDX_COMMAND = 16'h2014;
  localparam logic [15:0] IDX_STATUS  = 16'h2016;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG  = {IDX_CONFIG[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_FRAME   = {IDX_FRAME[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = {IDX_COMMAND[13:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS[13:0], 2'b00};

  // configuration fields
  localparam int CFG_EN     = 0;
  localparam int CFG_CLKSEL = 1;  // three bits
  localparam int CFG_MODE   = 4;  // three bits, input port choice
  localparam int CFG_EMB    = 7;
  localparam logic [15:0] CONFIG_MASK  = 16'h01ff;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;

  // frame setting fields
  localparam int FRM_IRQ_EN  = 0;
  localparam int FRM_IRQ_POL = 1;
  localparam int FRM_DEC     = 2;  // three bits
  localparam int FRM_SINGLE  = 6;
  localparam int FRM_IRQ_SEL = 7;
  localparam int FRM_RAW     = 8;
  localparam logic [15:0] FRAME_MASK  = 16'h01df;
  localparam logic [15:0] FRAME_RESET = 16'h0000;

  // command bits (write only) and status bits
  localparam int CMD_RESET    = 0;
  localparam int CMD_IRQ_CLR  = 1;
  localparam int CMD_START    = 2;
  localparam int CMD_STOP     = 3;
  localparam int CMD_ERR0_CLR = 8;
  localparam int CMD_ERR1_CLR = 9;
  localparam int STS_IRQ  = 1;
  localparam int STS_RUN  = 2;
  localparam int STS_ERR0 = 8;
  localparam int STS_ERR1 = 9;

  typedef enum logic [2:0] {
    CLKSEL_FOLLOW = 3'b000,
    CLKSEL_PORT1  = 3'b001,
    CLKSEL_PORT2  = 3'b010,
    CLKSEL_BOTH   = 3'b011,
    CLKSEL_NONE   = 3'b100
  } clk_sel_t;

  localparam logic [2:0] MODE_PORT1 = 3'h0;
  localparam logic [2:0] MODE_PORT2 = 3'h1;
  localparam logic [2:0] DEC_NONE   = 3'h7;
  localparam logic [7:0] PAD_BYTE   = 8'hff;
  localparam logic [7:0] SYNC_LEAD  = 8'hff;
  localparam logic [7:0] SYNC_ZERO  = 8'h00;
  localparam int SYNC_FIXED_BIT = 7;
  localparam int SYNC_V_BIT     = 5;
  localparam int SYNC_H_BIT     = 4;

  typedef enum logic [1:0] {
    CAP_IDLE  = 2'b00,
    CAP_FRAME = 2'b01,
    CAP_PAD   = 2'b10
  } cap_state_t;

  typedef enum logic [1:0] {
    ES_DATA = 2'b00,
    ES_LEAD = 2'b01,
    ES_ZERO = 2'b10,
    ES_CODE = 2'b11
  } esync_state_t;

  // sensor clock half period
  localparam int CLK_PERIOD_NS        = 5;
  localparam int SENSOR_HALF_NS       = 10;
  localparam int SENSOR_HALF_CYC      = SENSOR_HALF_NS / CLK_PERIOD_NS;

endpackage

// [hw/camera_capture_control.sv]
// camera capture control: APB registers, sensor clock out, frame capture
// assumes APB master on clock; sensor pins are asynchronous to clock
//
// Behaviour
// - clock select routes sensor clock to ports
// - enable low stops clock, output held low
// - clearing enable forces clock output low immediately
// - software reset clears logic, partial data, enable
// - raw bit accepts already encoded sensor stream
// - raw mode needs enable, changes during blanking
// - raw frames padded with 0xff to words
// - interrupt select: during frame or after
// - single frame clears enable after one frame
// - decimation code n picks one of n+1 frames, code 7 takes none
// - polarity bit picks vertical ref level
// - interrupt enable gates frame interrupt
// - command bits act on one only
// - sync error clears only in embedded mode
// - stop command finishes frame then halts
// - start command begins at next frame
// - interrupt clear command clears status flag
// - embedded mode takes sync from data codes
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module camera_capture_control #(
  parameter int DIV_HALF = camera_capture_pkg::SENSOR_HALF_CYC
) (
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  input  wire logic [camera_capture_pkg::ADDR_W-1:0] paddr,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              sensor_pixel_clock,
  input  wire logic                              sensor_vertical_ref,
  input  wire logic                              sensor_line_ref,
  input  wire logic [7:0]                        sensor_data,
  output logic                                   sensor_clock_out_port1,
  output logic                                   sensor_clock_out_port2,
  output logic                                   capture_irq,
  output logic [31:0]                            pixel_word,
  output logic                                   pixel_word_valid
);
  import camera_capture_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // apb decode: zero-wait slave, answer one cycle into the access phase
  logic        setup_w, done_w, wr_w;
  logic        hit_cfg, hit_frm, hit_cmd, hit_sts, hit_any;
  logic [15:0] cfg_reg, cfg_next, frm_reg, frm_next, sts_w, rd_mux;

  assign setup_w = psel & ~penable;
  assign done_w  = psel & penable & pready;
  assign wr_w    = done_w & pwrite;
  assign hit_cfg = (paddr == ADDR_CONFIG);
  assign hit_frm = (paddr == ADDR_FRAME);
  assign hit_cmd = (paddr == ADDR_COMMAND);
  assign hit_sts = (paddr == ADDR_STATUS);
  assign hit_any = hit_cfg | hit_frm | hit_cmd | hit_sts;
  // command register holds no readable state
  assign rd_mux  = hit_cfg ? cfg_reg : hit_frm ? frm_reg :
                   hit_sts ? sts_w : 16'h0000;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~hit_any;
      prdata  <= (setup_w & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // command pulses: a zero bit does nothing
  logic cmd_wr, cmd_reset, cmd_irq_clr, cmd_start, cmd_stop;
  logic cmd_err0_clr, cmd_err1_clr;
  assign cmd_wr       = wr_w & hit_cmd;
  assign cmd_reset    = cmd_wr & pwdata[CMD_RESET];
  assign cmd_irq_clr  = cmd_wr & pwdata[CMD_IRQ_CLR];
  assign cmd_start    = cmd_wr & pwdata[CMD_START];
  assign cmd_stop     = cmd_wr & pwdata[CMD_STOP];
  assign cmd_err0_clr = cmd_wr & pwdata[CMD_ERR0_CLR];
  assign cmd_err1_clr = cmd_wr & pwdata[CMD_ERR1_CLR];

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before anything looks at the pins
  logic [10:0] pin_meta_reg, pin_sync_reg;
  logic        pclk_prev_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg  <= 11'h000;
      pin_sync_reg  <= 11'h000;
      pclk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg  <= {sensor_pixel_clock, sensor_vertical_ref,
                        sensor_line_ref, sensor_data};
      pin_sync_reg  <= pin_meta_reg;
      pclk_prev_reg <= pin_sync_reg[10];
    end
  end

  logic       pix_edge, vref_s, href_s;
  logic [7:0] data_s;
  assign pix_edge = pin_sync_reg[10] & ~pclk_prev_reg;
  assign vref_s   = pin_sync_reg[9];
  assign href_s   = pin_sync_reg[8];
  assign data_s   = pin_sync_reg[7:0];

  ////////////////////////////////////////////////////////////////////////
  // embedded sync decoder: lead, zero, zero, code word
  esync_state_t es_reg;
  logic emb_vact_reg, emb_line_reg, err0_reg, err1_reg;
  logic err0_set, err1_set, emb_mode;
  assign emb_mode = cfg_reg[CFG_EMB];
  assign err1_set = pix_edge & emb_mode &
                    (es_reg == ES_LEAD || es_reg == ES_ZERO) &
                    (data_s != SYNC_ZERO);
  assign err0_set = pix_edge & emb_mode & (es_reg == ES_CODE) &
                    ~data_s[SYNC_FIXED_BIT];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      es_reg       <= ES_DATA;
      emb_vact_reg <= 1'b0;
      emb_line_reg <= 1'b0;
    end else if (cmd_reset || !emb_mode) begin
      es_reg <= ES_DATA;
    end else if (pix_edge) begin
      unique case (es_reg)
        ES_DATA: es_reg <= (data_s == SYNC_LEAD) ? ES_LEAD : ES_DATA;
        ES_LEAD: es_reg <= (data_s == SYNC_ZERO) ? ES_ZERO : ES_DATA;
        ES_ZERO: es_reg <= (data_s == SYNC_ZERO) ? ES_CODE : ES_DATA;
        ES_CODE: begin
          es_reg <= ES_DATA;
          if (data_s[SYNC_FIXED_BIT]) begin
            emb_vact_reg <= ~data_s[SYNC_V_BIT];
            emb_line_reg <= ~data_s[SYNC_H_BIT];
          end
        end
      endcase
    end
  end

  // error flags: a new error wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err0_reg <= 1'b0;
      err1_reg <= 1'b0;
    end else begin
      err0_reg <= err0_set | (err0_reg & ~(cmd_err0_clr & emb_mode));
      err1_reg <= err1_set | (err1_reg & ~(cmd_err1_clr & emb_mode));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame framing: sync source chosen by the embedded mode bit
  logic vert_active, line_active, byte_ok, vert_prev_reg;
  logic frame_start, frame_end;
  assign vert_active = emb_mode ? emb_vact_reg : vref_s;
  assign line_active = emb_mode ? emb_line_reg : href_s;
  assign byte_ok     = ~emb_mode | ((es_reg == ES_DATA) &&
                                    (data_s != SYNC_LEAD));
  assign frame_start = vert_active & ~vert_prev_reg;
  assign frame_end   = ~vert_active & vert_prev_reg;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) vert_prev_reg <= 1'b0;
    else         vert_prev_reg <= vert_active;
  end

  ////////////////////////////////////////////////////////////////////////
  // capture sequencer
  cap_state_t state_reg, state_next;
  logic       cfg_en, running_reg, stop_pend_reg, raw_eff_reg;
  logic [2:0] dec_code, dec_cnt_reg;
  logic       dec_hit, take_frame, done_pulse, take_byte;
  assign cfg_en     = cfg_reg[CFG_EN];
  assign dec_code   = frm_reg[FRM_DEC +: 3];
  assign dec_hit    = (dec_code != DEC_NONE) && (dec_cnt_reg == 3'h0);
  assign take_frame = cfg_en & running_reg & dec_hit;
  assign done_pulse = (state_reg == CAP_FRAME) & frame_end;
  assign take_byte  = (state_reg == CAP_FRAME) & pix_edge & line_active &
                      vert_active & byte_ok;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CAP_IDLE:  if (frame_start && take_frame) state_next = CAP_FRAME;
      CAP_FRAME: if (frame_end) begin
        state_next = raw_eff_reg ? CAP_PAD : CAP_IDLE;
      end
      CAP_PAD:   state_next = CAP_IDLE;
      default:   state_next = CAP_IDLE;
    endcase
    if (!cfg_en || cmd_reset) state_next = CAP_IDLE;
  end

  // start/stop flag: start takes hold at once; stop during a frame waits for its end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= CAP_IDLE;
      running_reg   <= 1'b1;
      stop_pend_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (cmd_reset) begin
        running_reg   <= ~frm_reg[FRM_SINGLE];
        stop_pend_reg <= 1'b0;
      end else if (cmd_start) begin
        running_reg   <= 1'b1;
        stop_pend_reg <= 1'b0;
      end else if (cmd_stop) begin
        if (state_reg == CAP_FRAME) stop_pend_reg <= 1'b1;
        else                        running_reg   <= 1'b0;
      end else if (done_pulse && stop_pend_reg) begin
        running_reg   <= 1'b0;
        stop_pend_reg <= 1'b0;
      end
    end
  end

  // decimation counter; restarts so the first eligible frame is taken
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dec_cnt_reg <= 3'h0;
    end else if (cmd_reset || !cfg_en ||
                 (wr_w && hit_frm &&
                  pwdata[FRM_DEC +: 3] != dec_code)) begin
      dec_cnt_reg <= 3'h0;
    end else if (frame_start) begin
      dec_cnt_reg <= (dec_cnt_reg >= dec_code) ? 3'h0
                                               : dec_cnt_reg + 3'h1;
    end
  end

  // raw mode follows its bit only in blanking with capture idle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) raw_eff_reg <= 1'b0;
    else if (!cfg_en || cmd_reset) raw_eff_reg <= 1'b0;
    else if (state_reg == CAP_IDLE && !vert_active)
      raw_eff_reg <= frm_reg[FRM_RAW];
  end

  ////////////////////////////////////////////////////////////////////////
  // byte packing, first byte in the low lane; raw frames padded
  logic [31:0] word_reg, word_next, pad_word;
  logic [1:0]  byte_cnt_reg;
  assign word_next = {data_s, word_reg[31:8]};
  always_comb begin
    unique case (byte_cnt_reg)
      2'h0: pad_word = {4{PAD_BYTE}};
      2'h1: pad_word = {{3{PAD_BYTE}}, word_reg[31:24]};
      2'h2: pad_word = {{2{PAD_BYTE}}, word_reg[31:16]};
      2'h3: pad_word = {PAD_BYTE, word_reg[31:8]};
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      word_reg         <= 32'h0000_0000;
      byte_cnt_reg     <= 2'h0;
      pixel_word       <= 32'h0000_0000;
      pixel_word_valid <= 1'b0;
    end else begin
      pixel_word_valid <= 1'b0;
      if (cmd_reset || (state_reg == CAP_IDLE &&
                        state_next == CAP_FRAME)) begin
        word_reg     <= 32'h0000_0000;
        byte_cnt_reg <= 2'h0;
      end else if (state_reg == CAP_PAD) begin
        pixel_word       <= pad_word;
        pixel_word_valid <= 1'b1;
        byte_cnt_reg     <= 2'h0;
      end else if (take_byte) begin
        word_reg     <= word_next;
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
        if (byte_cnt_reg == 2'h3) begin
          pixel_word       <= word_next;
          pixel_word_valid <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes; a bus write wins over the single-frame auto clear
  always_comb begin
    cfg_next = cfg_reg;
    frm_next = frm_reg;
    if (wr_w && hit_cfg) cfg_next = pwdata[15:0] & CONFIG_MASK;
    else if (cmd_reset) cfg_next[CFG_EN] = 1'b0;
    else if (done_pulse && frm_reg[FRM_SINGLE])
      cfg_next[CFG_EN] = 1'b0;
    if (wr_w && hit_frm) begin
      frm_next = pwdata[15:0] & FRAME_MASK;
      if (!cfg_en) frm_next[FRM_RAW] = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= CONFIG_RESET;
      frm_reg <= FRAME_RESET;
    end else begin
      cfg_reg <= cfg_next;
      frm_reg <= frm_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame interrupt: sticky flag, a new event beats the clear
  logic irq_sts_reg, vref_match, irq_event, irq_sts_next;
  assign vref_match   = vert_active ^ frm_reg[FRM_IRQ_POL];
  assign irq_event    = frm_reg[FRM_IRQ_SEL] ? done_pulse
                        : ((state_reg == CAP_FRAME) & vref_match);
  assign irq_sts_next = irq_event | (irq_sts_reg & ~cmd_irq_clr);
  assign sts_w = {6'h00, err1_reg, err0_reg, 5'h00, running_reg,
                  irq_sts_reg, 1'b0};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_sts_reg <= 1'b0;
      capture_irq <= 1'b0;
    end else begin
      irq_sts_reg <= irq_sts_next;
      capture_irq <= irq_sts_next & frm_reg[FRM_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sensor clock divider and port routing, from next config so the
  // output drops on the same edge that clears the enable
  clk_sel_t   sel_w;
  logic       en_next, sel1_w, sel2_w, clk_gen_reg, clk_gen_next, wrap_w;
  logic [7:0] div_cnt_reg;
  assign en_next = cfg_next[CFG_EN];
  assign sel_w   = clk_sel_t'(cfg_next[CFG_CLKSEL +: 3]);
  assign sel1_w  = (sel_w == CLKSEL_PORT1) || (sel_w == CLKSEL_BOTH) ||
                   (sel_w == CLKSEL_FOLLOW &&
                    cfg_next[CFG_MODE +: 3] == MODE_PORT1);
  assign sel2_w  = (sel_w == CLKSEL_PORT2) || (sel_w == CLKSEL_BOTH) ||
                   (sel_w == CLKSEL_FOLLOW &&
                    cfg_next[CFG_MODE +: 3] == MODE_PORT2);
  assign wrap_w  = (div_cnt_reg == 8'(DIV_HALF - 1));
  assign clk_gen_next = en_next & (wrap_w ? ~clk_gen_reg : clk_gen_reg);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_reg            <= 8'h00;
      clk_gen_reg            <= 1'b0;
      sensor_clock_out_port1 <= 1'b0;
      sensor_clock_out_port2 <= 1'b0;
    end else begin
      div_cnt_reg <= (!en_next || wrap_w) ? 8'h00 : div_cnt_reg + 8'h01;
      clk_gen_reg <= clk_gen_next;
      sensor_clock_out_port1 <= clk_gen_next & sel1_w;
      sensor_clock_out_port2 <= clk_gen_next & sel2_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_clk_off_low: assert property (!cfg_en |->
    !sensor_clock_out_port1 && !sensor_clock_out_port2)
    else $error("sensor clock toggles while disabled");
  a_clk_stop_now: assert property (cfg_en && !en_next |=>
    !sensor_clock_out_port1 && !sensor_clock_out_port2)
    else $error("sensor clock not low right after disable");
  a_clk_port_sel: assert property (
    cfg_reg[CFG_CLKSEL +: 3] == CLKSEL_PORT1 |-> !sensor_clock_out_port2)
    else $error("port two clock while port one only");
  a_clk_none_sel: assert property (
    cfg_reg[CFG_CLKSEL +: 3] == CLKSEL_NONE |->
    !sensor_clock_out_port1 && !sensor_clock_out_port2)
    else $error("clock output active while inactive selected");
  a_soft_reset: assert property (cmd_reset && !(wr_w && hit_cfg) |=>
    !cfg_en && byte_cnt_reg == 2'h0 && state_reg == CAP_IDLE)
    else $error("software reset left capture state");
  a_raw_needs_en: assert property (!cfg_en |=> !raw_eff_reg)
    else $error("raw mode active while disabled");
  a_pad_full: assert property (state_reg == CAP_PAD &&
    byte_cnt_reg == 2'h0 |=> pixel_word_valid && pixel_word == {4{PAD_BYTE}})
    else $error("aligned raw frame lacks full pad word");
  a_single_off: assert property (done_pulse && frm_reg[FRM_SINGLE] &&
    !(wr_w && hit_cfg) |=> !cfg_en)
    else $error("single frame left capture enabled");
  a_dec_none: assert property (state_reg == CAP_IDLE &&
    dec_code == DEC_NONE |=> state_reg != CAP_FRAME)
    else $error("frame taken with decimation off");
  a_irq_gated: assert property (!frm_reg[FRM_IRQ_EN] |=> !capture_irq)
    else $error("interrupt raised while disabled");
  a_irq_clear: assert property (cmd_irq_clr && !irq_event |=>
    !irq_sts_reg ##1 !capture_irq || irq_sts_reg)
    else $error("interrupt flag survived clear");
  a_err_hold: assert property (cmd_err0_clr && !emb_mode && !err0_set |=>
    err0_reg == $past(err0_reg))
    else $error("sync error cleared outside embedded mode");
  a_stop_frame: assert property (cmd_stop && state_reg == CAP_FRAME &&
    !cmd_reset |=> running_reg)
    else $error("stop halted capture mid frame");

  c_frame_taken: cover property (state_reg == CAP_IDLE ##1
                                 state_reg == CAP_FRAME);
  c_raw_pad:     cover property (state_reg == CAP_PAD);
  c_irq_raised:  cover property (!capture_irq ##1 capture_irq);
  c_single_done: cover property (done_pulse && frm_reg[FRM_SINGLE]);

endmodule

// [test/camera_sensor_model.sv]
// sensor model: sends frames of bytes on its own 64 ns pixel clock
// assumes the bench calls send_frame; the clock stands still between frames
`timescale 1ns/1ps
module camera_sensor_model (
  output logic       pclk,
  output logic       vref,
  output logic       href,
  output logic [7:0] data
);
  initial begin
    {pclk, vref, href, data} = 11'h0;
  end
  //////////////////////////////////////////
  // one line per frame; data moves on the falling edge, held across rise
  task automatic send_frame(input logic [7:0] b[$]);
    vref = 1'b1;
    #200;
    href = 1'b1;
    foreach (b[i]) begin
      data = b[i];
      #32 pclk = 1'b1;
      #32 pclk = 1'b0;
    end
    href = 1'b0;
    data = ~data; // stale byte never repeats after the line
    #200 vref = 1'b0;
    #400;
  endtask
endmodule

// [test/camera_capture_control_bench.sv]
// bench: APB register traffic and sensor frames against the capture block
// assumes camera_sensor_model drives the link pins
`timescale 1ns/1ps
module camera_capture_control_bench;
  import camera_capture_pkg::*;
  typedef logic [31:0] wq_t[$];
  logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, pixel_word, r;
  logic pready, pslverr, sensor_pixel_clock, sensor_vertical_ref;
  logic sensor_line_ref, capture_irq, pixel_word_valid;
  logic sensor_clock_out_port1, sensor_clock_out_port2;
  logic [7:0] sensor_data;
  logic [1:0] seen;
  logic [2:0] m;
  wq_t words;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  camera_capture_control #(.DIV_HALF(8)) uut (.clock, .arst_n, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .sensor_pixel_clock, .sensor_vertical_ref, .sensor_line_ref,
    .sensor_data, .sensor_clock_out_port1, .sensor_clock_out_port2,
    .capture_irq, .pixel_word, .pixel_word_valid);
  camera_sensor_model cam (.pclk(sensor_pixel_clock),
    .vref(sensor_vertical_ref), .href(sensor_line_ref), .data(sensor_data));
  //////////////////////////////////////////
  // clock, word collector and a hang limit well above the run length
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (pixel_word_valid === 1'b1) words.push_back(pixel_word);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    {r, slv} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // expected words: first byte in the low lane, raw frames padded with ff
  function automatic wq_t pack(logic [7:0] b[$], bit raw, bit taken);
    wq_t e;
    if (raw) do b.push_back(PAD_BYTE); while (b.size() % 4 != 0);
    for (int i = 0; taken && i + 3 < b.size(); i += 4)
      e.push_back({b[i+3], b[i+2], b[i+1], b[i]});
    return e;
  endfunction
  task automatic frame_chk(input int n, input bit raw, input bit taken);
    logic [7:0] b[$];
    wq_t e;
    for (int i = 0; i < n; i++) b.push_back(8'($urandom));
    e = pack(b, raw, taken);
    words = {};
    cam.send_frame(b);
    repeat (10) @(posedge clock);
    chk(words.size(), e.size());
    foreach (e[i]) chk(words[i], e[i]);
  endtask
  //////////////////////////////////////////
  initial begin
    void'($urandom(32'hdcf5));
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    rd(ADDR_CONFIG, 32'h0);
    rd(ADDR_STATUS, 32'h4);
    rd(ADDR_COMMAND, 32'h0);
    rd(16'h0000, 32'h0);
    chk(slv, 1'b1);
    wr(ADDR_FRAME, 32'h100);
    rd(ADDR_FRAME, 32'h0);
    wr(ADDR_CONFIG, 32'h6);
    seen = 0;
    repeat (20) @(posedge clock) seen |= {sensor_clock_out_port1, sensor_clock_out_port2};
    chk(seen, 2'b00);
    for (int s = 0; s < 5; s++) begin
      m = 3'($urandom % 2);
      wr(ADDR_CONFIG, 32'({m, 3'(s), 1'b1}));
      seen = 0;
      repeat (20) @(posedge clock) seen |= {sensor_clock_out_port1, sensor_clock_out_port2};
      chk(seen, {s==1 || s==3 || (s==0 && m==0), s==2 || s==3 || (s==0 && m==1)});
    end
    wr(ADDR_CONFIG, 32'h7);
    wait (sensor_clock_out_port1 === 1'b1);
    wr(ADDR_CONFIG, 32'h6);
    #1 chk({sensor_clock_out_port1, sensor_clock_out_port2}, 2'b00);
    wr(ADDR_CONFIG, 32'h7);
    wr(ADDR_COMMAND, 32'h0);
    rd(ADDR_CONFIG, 32'h7);
    wr(ADDR_FRAME, 32'h81);
    frame_chk(7, 0, 1);
    chk(capture_irq, 1'b1);
    wr(ADDR_COMMAND, 32'h2);
    repeat (3) @(posedge clock);
    chk(capture_irq, 1'b0);
    wr(ADDR_FRAME, 32'h100);
    rd(ADDR_FRAME, 32'h100);
    frame_chk(5, 1, 1);
    frame_chk(8, 1, 1);
    wr(ADDR_FRAME, 32'h1d);
    frame_chk(4, 0, 0);
    chk(capture_irq, 1'b1);
    wr(ADDR_FRAME, 32'h04);
    frame_chk(4, 0, 1);
    frame_chk(4, 0, 0);
    chk(capture_irq, 1'b0);
    wr(ADDR_COMMAND, 32'h1);
    rd(ADDR_CONFIG, 32'h6);
    wr(ADDR_FRAME, 32'h40);
    wr(ADDR_CONFIG, 32'h7);
    frame_chk(4, 0, 1);
    rd(ADDR_CONFIG, 32'h6);
    // stop while idle drops the flag at once; start brings capture back
    wr(ADDR_FRAME, 32'h0);
    wr(ADDR_CONFIG, 32'h7);
    wr(ADDR_COMMAND, 32'ha);
    rd(ADDR_STATUS, 32'h0);
    frame_chk(4, 0, 0);
    wr(ADDR_COMMAND, 32'h4);
    rd(ADDR_STATUS, 32'h4);
    frame_chk(4, 0, 1);
    report_and_stop;
  end
endmodule
